// ==== shared/gnsp_regs.svh ====
/*
  Constants of the navigation serial port: clock rate, reset values,
  frame layout, pulse timing and the host controller register map.
  Assumes inclusion by its bare name from the package and the ends.
*/
`ifndef GNSP_REGS_SVH
`define GNSP_REGS_SVH
// Core clock and frame layout
`define GNSP_CLK_HZ       20000000
`define GNSP_DATA_BITS    8
// Reset values
`define GNSP_BAUD_RST     3'h5
`define GNSP_SENT_RST     4'hf
// Timing pulse
`define GNSP_PPS_HIGH_MS  100
`define GNSP_PPS_MIN_SATS 6'h04
// Host controller registers, byte offsets
`define GNSP_CTRL_OFS     12'h000
`define GNSP_STAT_OFS     12'h004
`define GNSP_TXD_OFS      12'h008
`define GNSP_RXD_OFS      12'h00c
// Status fields and receive data valid bit
`define GNSP_ST_TXFULL    0
`define GNSP_ST_TXBUSY    1
`define GNSP_ST_RXAVAIL   2
`define GNSP_ST_OVERRUN   3
`define GNSP_ST_FRAMEERR  4
`define GNSP_RXD_VALID    8
`endif

// ==== shared/gnsp_pkg.sv ====
/*
  Types and the rate divisor function of the navigation serial port.
  Assumes gnsp_regs.svh on the include path.
*/
`include "gnsp_regs.svh"
package gnsp_pkg;
  // Line rate codes
  typedef enum logic [2:0] {
    GNSP_B9600 = 3'h0, GNSP_B14400 = 3'h1, GNSP_B19200 = 3'h2,
    GNSP_B38400 = 3'h3, GNSP_B57600 = 3'h4, GNSP_B115200 = 3'h5,
    GNSP_B961200 = 3'h6
  } gnsp_baud_e;
  // Character engine states
  typedef enum logic [3:0] {
    GNSP_IDLE = 4'h1, GNSP_START = 4'h2, GNSP_DATA = 4'h4,
    GNSP_STOP = 4'h8
  } gnsp_state_e;
  typedef logic [15:0] gnsp_div_t;
  // Clock cycles per bit, rounded to nearest
  function automatic gnsp_div_t gnsp_div(input logic [2:0] sel);
    int rate;
    case (sel)
      GNSP_B9600:   rate = 9600;
      GNSP_B14400:  rate = 14400;
      GNSP_B19200:  rate = 19200;
      GNSP_B38400:  rate = 38400;
      GNSP_B57600:  rate = 57600;
      GNSP_B961200: rate = 961200;
      default:      rate = 115200;
    endcase
    return gnsp_div_t'((`GNSP_CLK_HZ + rate / 2) / rate);
  endfunction : gnsp_div
endpackage : gnsp_pkg

// ==== shared/gnsp_if.sv ====
/*
  The two serial lines between the module and the host terminal.
  Assumes both lines idle high; no handshake or clock line exists.
*/
`timescale 1ns/1ps
interface gnsp_if;
  logic host_receive_line;   // Module to host
  logic host_transmit_line;  // Host to module
  modport dev  (output host_receive_line, input host_transmit_line);
  modport host (input host_receive_line, output host_transmit_line);
endinterface : gnsp_if

// ==== src/gnsp_fifo2.sv ====
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
module gnsp_fifo2 #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] mem_reg [2];
  logic [W-1:0] mem_next [2];
  logic [1:0]   cnt_reg, cnt_next;
  logic         rd_reg, rd_next, wr_reg, wr_next;
  logic         push, pop;

  // Handshakes and head word
  assign in_ready  = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data  = mem_reg[rd_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer and count update
  always_comb begin
    mem_next = mem_reg;
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    cnt_next = cnt_reg;
    if (push) begin
      mem_next[wr_reg] = in_data;
      wr_next = !wr_reg;
    end
    if (pop) rd_next = !rd_reg;
    if (push && !pop) cnt_next = cnt_reg + 2'h1;
    else if (pop && !push) cnt_next = cnt_reg - 2'h1;
  end

  // Registers
  always_ff @(posedge clk) begin
    mem_reg <= mem_next;
    if (rst) begin
      cnt_reg <= 2'h0;
      rd_reg  <= 1'b0;
      wr_reg  <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      rd_reg  <= rd_next;
      wr_reg  <= wr_next;
    end
  end
endmodule : gnsp_fifo2

// ==== src/gnsp_dev.sv ====
/*
  Module end of the navigation serial port: sentence transmitter,
  command receiver, rate and sentence selection, one-pulse-per-second.
  Assumes the host framing matches; user-side inputs share clk.
*/
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "gnsp_regs.svh"
// What this block does
// - Seven selectable bit rates, both sides equal
// - Reset to 115200, eight data, no parity
// - No handshake lines, no clocked mode
// - Module drives host receive line
// - Host drives line the module receives
// - Sentences out, commands in, one port
// - Default sentences RMC, GGA, GSV, GSA
// - Pulse each UTC second with 3D fix and at least four satellites
// - No fix holds timing output low
// - Exactly one serial port for host
module gnsp_dev
  import gnsp_pkg::*;
#(
  parameter int PPS_HIGH_CYC = `GNSP_PPS_HIGH_MS * (`GNSP_CLK_HZ / 1000)
) (
  input  wire logic       clk,
  input  wire logic       rst,
  gnsp_if.dev             lnk,
  input  wire logic       baud_wr,
  input  wire logic [2:0] baud_sel,
  output logic [2:0]      baud_now,
  input  wire logic       sent_wr,
  input  wire logic [3:0] sent_mask_in,
  output logic [3:0]      sent_mask,
  input  wire logic       nmea_valid,
  output logic            nmea_ready,
  input  wire logic [7:0] nmea_data,
  output logic            cmd_valid,
  input  wire logic       cmd_ready,
  output logic [7:0]      cmd_data,
  output logic            cmd_overrun,
  output logic            cmd_frame_err,
  input  wire logic       fix_3d,
  input  wire logic [5:0] sats_used,
  input  wire logic       utc_sec_tick,
  output logic            pps_out
);
  localparam logic [2:0] LAST_BIT = 3'(`GNSP_DATA_BITS - 1);
  logic [2:0]  baud_reg, baud_next;
  logic [3:0]  sent_reg, sent_next;
  gnsp_div_t   div;
  // Transmitter state
  gnsp_state_e tx_st_reg, tx_st_next;
  gnsp_div_t   tx_cnt_reg, tx_cnt_next;
  logic [2:0]  tx_bit_reg, tx_bit_next;
  logic [7:0]  tx_sh_reg, tx_sh_next;
  logic        tx_line_reg, tx_line_next;
  logic        txq_valid, txq_pop;
  logic [7:0]  txq_data;
  // Receiver state
  gnsp_state_e rx_st_reg, rx_st_next;
  gnsp_div_t   rx_cnt_reg, rx_cnt_next;
  logic [2:0]  rx_bit_reg, rx_bit_next;
  logic [7:0]  rx_sh_reg, rx_sh_next;
  logic        rx_m_reg, rx_s_reg;
  logic        rx_push, rxq_ready;
  logic        ovr_reg, ovr_next, ferr_reg, ferr_next;
  // Timing pulse state
  logic        pps_reg, pps_next;
  logic [31:0] pps_cnt_reg, pps_cnt_next;
  logic        fix_ok;

  // rate select; reset rate; sentence set
  always_comb begin
    baud_next = baud_sel_ok(baud_wr) ? baud_sel : baud_reg;
    sent_next = sent_wr ? sent_mask_in : sent_reg;
  end
  function automatic logic baud_sel_ok(input logic wr);
    return wr && (baud_sel <= 3'h6);
  endfunction : baud_sel_ok
  assign div       = gnsp_div(baud_reg);
  assign baud_now  = baud_reg;
  assign sent_mask = sent_reg;

  // Outgoing sentence bytes wait here while a character is sent
  gnsp_fifo2 #(.W(8)) u_txq (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (nmea_valid),
    .in_ready  (nmea_ready),
    .in_data   (nmea_data),
    .out_valid (txq_valid),
    .out_ready (txq_pop),
    .out_data  (txq_data)
  );

  always_comb begin
    tx_st_next   = tx_st_reg;
    tx_cnt_next  = tx_cnt_reg - 16'h0001;
    tx_bit_next  = tx_bit_reg;
    tx_sh_next   = tx_sh_reg;
    tx_line_next = tx_line_reg;
    txq_pop      = 1'b0;
    case (tx_st_reg)
      GNSP_IDLE: begin
        tx_line_next = 1'b1;
        tx_cnt_next  = div - 16'h0001;
        if (txq_valid) begin
          txq_pop      = 1'b1;
          tx_sh_next   = txq_data;
          tx_line_next = 1'b0;
          tx_st_next   = GNSP_START;
        end
      end
      GNSP_START: if (tx_cnt_reg == 16'h0000) begin
        tx_line_next = tx_sh_reg[0];
        tx_sh_next   = tx_sh_reg >> 1;
        tx_bit_next  = 3'h0;
        tx_cnt_next  = div - 16'h0001;
        tx_st_next   = GNSP_DATA;
      end
      GNSP_DATA: if (tx_cnt_reg == 16'h0000) begin
        tx_cnt_next = div - 16'h0001;
        if (tx_bit_reg == LAST_BIT) begin
          tx_line_next = 1'b1;
          tx_st_next   = GNSP_STOP;
        end else begin
          tx_line_next = tx_sh_reg[0];
          tx_sh_next   = tx_sh_reg >> 1;
          tx_bit_next  = tx_bit_reg + 3'h1;
        end
      end
      GNSP_STOP: if (tx_cnt_reg == 16'h0000) tx_st_next = GNSP_IDLE;
      default: tx_st_next = GNSP_IDLE;
    endcase
  end

  // module drives the host receive line
  assign lnk.host_receive_line = tx_line_reg;

  // receive frame sampling at bit centres
  always_comb begin
    rx_st_next  = rx_st_reg;
    rx_cnt_next = rx_cnt_reg - 16'h0001;
    rx_bit_next = rx_bit_reg;
    rx_sh_next  = rx_sh_reg;
    rx_push     = 1'b0;
    ferr_next   = 1'b0;
    case (rx_st_reg)
      GNSP_IDLE: begin
        rx_cnt_next = (div >> 1) - 16'h0001;
        if (!rx_s_reg) rx_st_next = GNSP_START;
      end
      GNSP_START: if (rx_cnt_reg == 16'h0000) begin
        rx_cnt_next = div - 16'h0001;
        rx_bit_next = 3'h0;
        rx_st_next  = rx_s_reg ? GNSP_IDLE : GNSP_DATA;
      end
      GNSP_DATA: if (rx_cnt_reg == 16'h0000) begin
        rx_cnt_next = div - 16'h0001;
        rx_sh_next  = {rx_s_reg, rx_sh_reg[7:1]};
        rx_bit_next = rx_bit_reg + 3'h1;
        if (rx_bit_reg == LAST_BIT) rx_st_next = GNSP_STOP;
      end
      GNSP_STOP: if (rx_cnt_reg == 16'h0000) begin
        rx_push    = rx_s_reg;
        ferr_next  = !rx_s_reg;
        rx_st_next = GNSP_IDLE;
      end
      default: rx_st_next = GNSP_IDLE;
    endcase
    // no flow control, a full buffer drops the character
    ovr_next = rx_push && !rxq_ready;
  end

  // received command bytes queued for the user
  gnsp_fifo2 #(.W(8)) u_rxq (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (rx_push),
    .in_ready  (rxq_ready),
    .in_data   (rx_sh_reg),
    .out_valid (cmd_valid),
    .out_ready (cmd_ready),
    .out_data  (cmd_data)
  );
  assign cmd_overrun   = ovr_reg;
  assign cmd_frame_err = ferr_reg;

  // pulse starts at the UTC second with a 3D fix and at least four satellites
  // no fix forces the output low
  always_comb begin
    fix_ok       = fix_3d && (sats_used >= `GNSP_PPS_MIN_SATS);
    pps_next     = pps_reg;
    pps_cnt_next = pps_cnt_reg;
    if (!fix_ok) begin
      pps_next = 1'b0;
    end else if (utc_sec_tick) begin
      pps_next     = 1'b1;
      pps_cnt_next = 32'(PPS_HIGH_CYC - 1);
    end else if (pps_reg) begin
      if (pps_cnt_reg == 32'h0000_0000) pps_next = 1'b0;
      else pps_cnt_next = pps_cnt_reg - 32'h0000_0001;
    end
  end
  assign pps_out = pps_reg;

  // host line passes two flip-flops before use
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_m_reg <= 1'b1;
      rx_s_reg <= 1'b1;
    end else begin
      rx_m_reg <= lnk.host_transmit_line;
      rx_s_reg <= rx_m_reg;
    end
  end

  // Registers of all groups
  always_ff @(posedge clk) begin
    if (rst) begin
      baud_reg    <= `GNSP_BAUD_RST;
      sent_reg    <= `GNSP_SENT_RST;
      tx_st_reg   <= GNSP_IDLE;
      tx_cnt_reg  <= 16'h0000;
      tx_bit_reg  <= 3'h0;
      tx_sh_reg   <= 8'h00;
      tx_line_reg <= 1'b1;
      rx_st_reg   <= GNSP_IDLE;
      rx_cnt_reg  <= 16'h0000;
      rx_bit_reg  <= 3'h0;
      rx_sh_reg   <= 8'h00;
      ovr_reg     <= 1'b0;
      ferr_reg    <= 1'b0;
      pps_reg     <= 1'b0;
      pps_cnt_reg <= 32'h0000_0000;
    end else begin
      baud_reg    <= baud_next;
      sent_reg    <= sent_next;
      tx_st_reg   <= tx_st_next;
      tx_cnt_reg  <= tx_cnt_next;
      tx_bit_reg  <= tx_bit_next;
      tx_sh_reg   <= tx_sh_next;
      tx_line_reg <= tx_line_next;
      rx_st_reg   <= rx_st_next;
      rx_cnt_reg  <= rx_cnt_next;
      rx_bit_reg  <= rx_bit_next;
      rx_sh_reg   <= rx_sh_next;
      ovr_reg     <= ovr_next;
      ferr_reg    <= ferr_next;
      pps_reg     <= pps_next;
      pps_cnt_reg <= pps_cnt_next;
    end
  end
endmodule : gnsp_dev

// ==== src/gnsp_host.sv ====
/*
  Host terminal end of the navigation serial port, an APB slave with
  control, status, transmit and receive registers.
  Assumes an APB master on clk; the module uses the same framing.
*/
`timescale 1ns/1ps
`include "gnsp_regs.svh"
module gnsp_host
  import gnsp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  gnsp_if.host             lnk,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  localparam logic [2:0] LAST_BIT = 3'(`GNSP_DATA_BITS - 1);
  logic [2:0]  baud_reg, baud_next;
  logic [31:0] rd_reg, rd_next;
  logic        ovr_reg, ovr_next, ferr_reg, ferr_next;
  logic        hit_c, hit_s, hit_t, hit_r, acc, done;
  gnsp_div_t   div;
  gnsp_state_e tx_st_reg, tx_st_next, rx_st_reg, rx_st_next;
  gnsp_div_t   tx_cnt_reg, tx_cnt_next, rx_cnt_reg, rx_cnt_next;
  logic [2:0]  tx_bit_reg, tx_bit_next, rx_bit_reg, rx_bit_next;
  logic [7:0]  tx_sh_reg, tx_sh_next, rx_sh_reg, rx_sh_next;
  logic        tx_line_reg, tx_line_next, rx_m_reg, rx_s_reg;
  logic        txq_in_ready, txq_valid, txq_pop;
  logic        rx_push, rx_bad, rxq_ready, rxq_valid, rxq_pop;
  logic [7:0]  txq_data, rxq_data;

  // Address decode; a full transmit buffer stalls the write
  always_comb begin
    hit_c = (paddr == `GNSP_CTRL_OFS);
    hit_s = (paddr == `GNSP_STAT_OFS);
    hit_t = (paddr == `GNSP_TXD_OFS);
    hit_r = (paddr == `GNSP_RXD_OFS);
    acc   = psel && penable;
    pready = !(pwrite && hit_t && !txq_in_ready);
    done  = acc && pready;
    pslverr = acc && !(hit_c || hit_s || hit_t || hit_r);
  end
  assign prdata  = rd_reg;
  assign rxq_pop = done && !pwrite && hit_r && rd_reg[`GNSP_RXD_VALID];
  assign div     = gnsp_div(baud_reg);

  // rate select; reset rate; read data captured in setup
  always_comb begin
    baud_next = baud_reg;
    rd_next   = rd_reg;
    if (done && pwrite && hit_c && pwdata[2:0] <= 3'h6)
      baud_next = pwdata[2:0];
    if (psel && !penable) begin
      rd_next = 32'h0000_0000;
      if (hit_c) rd_next[2:0] = baud_reg;
      else if (hit_s) begin
        rd_next[`GNSP_ST_TXFULL]   = !txq_in_ready;
        rd_next[`GNSP_ST_TXBUSY]   = (tx_st_reg != GNSP_IDLE) || txq_valid;
        rd_next[`GNSP_ST_RXAVAIL]  = rxq_valid;
        rd_next[`GNSP_ST_OVERRUN]  = ovr_reg;
        rd_next[`GNSP_ST_FRAMEERR] = ferr_reg;
      end else if (hit_r) rd_next[8:0] = {rxq_valid, rxq_data};
    end
    // no flow control; sticky errors, set wins over clear
    ovr_next  = ovr_reg;
    ferr_next = ferr_reg;
    if (done && pwrite && hit_s) begin
      if (pwdata[`GNSP_ST_OVERRUN])  ovr_next  = 1'b0;
      if (pwdata[`GNSP_ST_FRAMEERR]) ferr_next = 1'b0;
    end
    if (rx_push && !rxq_ready) ovr_next = 1'b1;
    if (rx_bad) ferr_next = 1'b1;
  end

  // Command bytes wait for the transmitter
  gnsp_fifo2 #(.W(8)) u_txq (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (acc && pwrite && hit_t),
    .in_ready  (txq_in_ready),
    .in_data   (pwdata[7:0]),
    .out_valid (txq_valid),
    .out_ready (txq_pop),
    .out_data  (txq_data)
  );
  // Sentence bytes wait for software
  gnsp_fifo2 #(.W(8)) u_rxq (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (rx_push),
    .in_ready  (rxq_ready),
    .in_data   (rx_sh_reg),
    .out_valid (rxq_valid),
    .out_ready (rxq_pop),
    .out_data  (rxq_data)
  );

  always_comb begin
    tx_st_next   = tx_st_reg;
    tx_cnt_next  = tx_cnt_reg - 16'h0001;
    tx_bit_next  = tx_bit_reg;
    tx_sh_next   = tx_sh_reg;
    tx_line_next = tx_line_reg;
    txq_pop      = 1'b0;
    case (tx_st_reg)
      GNSP_IDLE: begin
        tx_line_next = 1'b1;
        tx_cnt_next  = div - 16'h0001;
        if (txq_valid) begin
          txq_pop      = 1'b1;
          tx_sh_next   = txq_data;
          tx_line_next = 1'b0;
          tx_st_next   = GNSP_START;
        end
      end
      GNSP_START, GNSP_DATA: if (tx_cnt_reg == 16'h0000) begin
        tx_cnt_next = div - 16'h0001;
        if (tx_st_reg == GNSP_DATA && tx_bit_reg == LAST_BIT) begin
          tx_line_next = 1'b1;
          tx_st_next   = GNSP_STOP;
        end else begin
          tx_line_next = tx_sh_reg[0];
          tx_sh_next   = tx_sh_reg >> 1;
          tx_bit_next  = (tx_st_reg == GNSP_START) ? 3'h0
                                                   : tx_bit_reg + 3'h1;
          tx_st_next   = GNSP_DATA;
        end
      end
      GNSP_STOP: if (tx_cnt_reg == 16'h0000) tx_st_next = GNSP_IDLE;
      default: tx_st_next = GNSP_IDLE;
    endcase
    rx_st_next  = rx_st_reg;
    rx_cnt_next = rx_cnt_reg - 16'h0001;
    rx_bit_next = rx_bit_reg;
    rx_sh_next  = rx_sh_reg;
    rx_push     = 1'b0;
    rx_bad      = 1'b0;
    case (rx_st_reg)
      GNSP_IDLE: begin
        rx_cnt_next = (div >> 1) - 16'h0001;
        if (!rx_s_reg) rx_st_next = GNSP_START;
      end
      GNSP_START: if (rx_cnt_reg == 16'h0000) begin
        rx_cnt_next = div - 16'h0001;
        rx_bit_next = 3'h0;
        rx_st_next  = rx_s_reg ? GNSP_IDLE : GNSP_DATA;
      end
      GNSP_DATA: if (rx_cnt_reg == 16'h0000) begin
        rx_cnt_next = div - 16'h0001;
        rx_sh_next  = {rx_s_reg, rx_sh_reg[7:1]};
        rx_bit_next = rx_bit_reg + 3'h1;
        if (rx_bit_reg == LAST_BIT) rx_st_next = GNSP_STOP;
      end
      GNSP_STOP: if (rx_cnt_reg == 16'h0000) begin
        rx_push    = rx_s_reg;
        rx_bad     = !rx_s_reg;
        rx_st_next = GNSP_IDLE;
      end
      default: rx_st_next = GNSP_IDLE;
    endcase
  end

  // host drives the line the module receives
  assign lnk.host_transmit_line = tx_line_reg;

  // module line synchronised, then all registers
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_m_reg    <= 1'b1;
      rx_s_reg    <= 1'b1;
      baud_reg    <= `GNSP_BAUD_RST;
      rd_reg      <= 32'h0000_0000;
      ovr_reg     <= 1'b0;
      ferr_reg    <= 1'b0;
      tx_st_reg   <= GNSP_IDLE;
      tx_cnt_reg  <= 16'h0000;
      tx_bit_reg  <= 3'h0;
      tx_sh_reg   <= 8'h00;
      tx_line_reg <= 1'b1;
      rx_st_reg   <= GNSP_IDLE;
      rx_cnt_reg  <= 16'h0000;
      rx_bit_reg  <= 3'h0;
      rx_sh_reg   <= 8'h00;
    end else begin
      rx_m_reg    <= lnk.host_receive_line;
      rx_s_reg    <= rx_m_reg;
      baud_reg    <= baud_next;
      rd_reg      <= rd_next;
      ovr_reg     <= ovr_next;
      ferr_reg    <= ferr_next;
      tx_st_reg   <= tx_st_next;
      tx_cnt_reg  <= tx_cnt_next;
      tx_bit_reg  <= tx_bit_next;
      tx_sh_reg   <= tx_sh_next;
      tx_line_reg <= tx_line_next;
      rx_st_reg   <= rx_st_next;
      rx_cnt_reg  <= rx_cnt_next;
      rx_bit_reg  <= rx_bit_next;
      rx_sh_reg   <= rx_sh_next;
    end
  end
endmodule : gnsp_host

// ==== sim/gnsp_checker.sv ====
/*
  Checker of the two serial lines and the timing pulse.
  Assumes one clk domain and equal rates on both ends.
*/
`timescale 1ns/1ps
module gnsp_checker #(
  parameter int PPS_HIGH_CYC = 20
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       host_receive_line,
  input wire logic       host_transmit_line,
  input wire logic [2:0] baud_now,
  input wire logic       fix_3d,
  input wire logic [5:0] sats_used,
  input wire logic       utc_sec_tick,
  input wire logic       pps_out
);
  localparam int PW = PPS_HIGH_CYC + 2;
  localparam int RATES [7] = '{9600, 14400, 19200, 38400, 57600, 115200,
                               961200};
  int         per;
  int         fr_cnt [2];
  logic [1:0] act;
  logic [1:0] ln;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Bit period in cycles, rounded to nearest
  always_comb begin
    per = (20000000 + RATES[baud_now] / 2) / RATES[baud_now];
  end
  assign ln = {host_transmit_line, host_receive_line};
  // Cycles since start edge, up to middle of stop bit
  always_ff @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (rst || (act[i] && fr_cnt[i] == per * 19 / 2)) begin
        act[i] <= 1'b0;
        fr_cnt[i] <= 0;
      end else if (act[i]) begin
        fr_cnt[i] <= fr_cnt[i] + 1;
      end else if (!ln[i]) begin
        act[i] <= 1'b1;
        fr_cnt[i] <= 1;
      end
    end
  end
  chk_start_low: assert property (
    $fell(host_receive_line) |-> !host_receive_line [*8])
    else $error("start bit too short");
  chk_stop_rx: assert property (
    act[0] && fr_cnt[0] == per * 19 / 2 |-> host_receive_line)
    else $error("stop bit low toward host");
  chk_stop_tx: assert property (
    act[1] && fr_cnt[1] == per * 19 / 2 |-> host_transmit_line)
    else $error("stop bit low toward module");
  chk_bit_grid: assert property (
    $rose(host_receive_line) && act[0] |-> fr_cnt[0] % per == 0)
    else $error("bit edge off the period grid");
  chk_pps_tick: assert property (
    utc_sec_tick && fix_3d && sats_used >= 6'h04 |=> pps_out)
    else $error("no pulse after tick");
  chk_pps_nofix: assert property (
    !fix_3d |=> !pps_out)
    else $error("pulse without fix");
  chk_pps_width: assert property (
    $rose(pps_out) |-> pps_out [*8] ##[1:PW] !pps_out)
    else $error("pulse width wrong");
  chk_pps_cause: assert property (
    $rose(pps_out) |-> $past(utc_sec_tick) && $past(fix_3d))
    else $error("pulse without tick");
endmodule : gnsp_checker

// ==== sim/testbench.sv ====
/*
  Bench joining both ends: rates, framing, buffers, timing pulse.
  Assumes 20 MHz clk and a short pulse width parameter.
*/
`timescale 1ns/1ps
module testbench;
  logic        clk, rst, baud_wr, sent_wr, nmea_valid, nmea_ready;
  logic        cmd_valid, cmd_ready, cmd_overrun, cmd_frame_err;
  logic        fix_3d, utc_sec_tick, pps_out, psel, penable, pwrite;
  logic        pready, pslverr, e;
  logic [2:0]  baud_sel, baud_now;
  logic [3:0]  sent_mask_in, sent_mask;
  logic [5:0]  sats_used;
  logic [7:0]  nmea_data, cmd_data, b;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0]  q_up[$], q_dn[$], got[$];
  int          failures, total_checks, ovr, fe, pps_hi, seed;
  gnsp_if lnk ();
  gnsp_dev #(.PPS_HIGH_CYC(20)) i_gnsp_dev (.clk, .rst, .lnk, .baud_wr,
    .baud_sel, .baud_now, .sent_wr, .sent_mask_in, .sent_mask,
    .nmea_valid, .nmea_ready, .nmea_data, .cmd_valid, .cmd_ready,
    .cmd_data, .cmd_overrun, .cmd_frame_err, .fix_3d, .sats_used,
    .utc_sec_tick, .pps_out);
  gnsp_host i_gnsp_host (.clk, .rst, .lnk, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr);
  gnsp_checker #(.PPS_HIGH_CYC(20)) u_chk (.clk, .rst,
    .host_receive_line(lnk.host_receive_line),
    .host_transmit_line(lnk.host_transmit_line), .baud_now, .fix_3d,
    .sats_used, .utc_sec_tick, .pps_out);
  always #25 clk = ~clk;
  // Collect commands, error pulses and pulse-high cycles
  always @(posedge clk) begin
    if (!rst && cmd_valid === 1'b1 && cmd_ready === 1'b1)
      got.push_back(cmd_data);
    if (!rst && cmd_overrun === 1'b1)
      ovr++;
    if (!rst && cmd_frame_err === 1'b1)
      fe++;
    if (!rst && pps_out === 1'b1)
      pps_hi++;
  end
  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("Error %0t %s", $time, m);
    end
  endtask : chk
  // One APB transfer, waits for pready
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  // Offer one byte to the sentence stream
  task automatic push(input logic [7:0] v);
    nmea_valid <= 1'b1;
    nmea_data <= v;
    @(posedge clk);
    while (nmea_ready !== 1'b1) @(posedge clk);
  endtask : push
  // Poll the host receive register for n bytes
  task automatic poll(input int n);
    while (n > 0) begin
      apb(1'b0, 12'h00c, 32'h0);
      if (r[8] === 1'b1) begin
        chk(r[7:0] === q_up.pop_front(), "byte to host");
        n--;
      end
    end
  endtask : poll
  // n bytes each way at once
  task automatic duplex(input int n);
    repeat (n) begin
      b = 8'($random(seed));
      q_dn.push_back(b);
      apb(1'b1, 12'h008, {24'h0, b});
    end
    fork
      begin
        repeat (n) begin
          q_up.push_back(8'($random(seed)));
          push(q_up[q_up.size() - 1]);
        end
        nmea_valid <= 1'b0;
      end
      poll(n);
    join
    while (got.size() < n) @(posedge clk);
    repeat (n) chk(got.pop_front() === q_dn.pop_front(), "to module");
  endtask : duplex
  // Same rate code on both ends
  task automatic rate(input int c, input int ex);
    baud_sel <= 3'(c);
    baud_wr <= 1'b1;
    @(posedge clk);
    baud_wr <= 1'b0;
    apb(1'b1, 12'h000, 32'(c));
    apb(1'b0, 12'h000, 32'h0);
    chk(baud_now === 3'(ex) && r === 32'(ex), "rate code");
  endtask : rate
  task automatic wrap_up();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  // Time limit on the whole run
  initial begin
    repeat (95000) @(posedge clk);
    failures++;
    wrap_up();
  end
  // Main sequence
  initial begin
    seed = 60;
    {clk, baud_wr, sent_wr, nmea_valid, fix_3d, utc_sec_tick} = '0;
    {psel, penable, pwrite, baud_sel, sent_mask_in, sats_used} = '0;
    {nmea_data, paddr, pwdata} = '0;
    rst = 1'b1;
    cmd_ready = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(baud_now === 3'h5 && sent_mask === 4'hf, "reset state");
    chk(lnk.host_receive_line === 1'b1 && pps_out === 1'b0, "idle");
    apb(1'b0, 12'h000, 32'h0);
    chk(r === 32'h0000_0005, "reset rate register");
    apb(1'b0, 12'h004, 32'h0);
    chk(r === 32'h0, "reset status");
    apb(1'b0, 12'h010, 32'h0);
    chk(e === 1'b1 && r === 32'h0, "unmapped access");
    sent_mask_in <= 4'h5;
    sent_wr <= 1'b1;
    @(posedge clk);
    sent_wr <= 1'b0;
    @(posedge clk);
    chk(sent_mask === 4'h5, "sentence mask");
    for (int c = 0; c < 8; c++) begin
      rate(c, c < 7 ? c : 6);
      if (c < 7)
        duplex(1);
    end
    rate(5, 5);
    duplex(4);
    // Receiver stalled: third byte must be lost, first two kept
    cmd_ready <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      b = 8'($random(seed));
      if (i < 2)
        q_dn.push_back(b);
      apb(1'b1, 12'h008, {24'h0, b});
    end
    repeat (5 * 1740) @(posedge clk);
    chk(ovr == 1, "one overrun");
    cmd_ready <= 1'b1;
    repeat (4) @(posedge clk);
    chk(got.size() == 2, "kept bytes");
    repeat (2) chk(got.pop_front() === q_dn.pop_front(), "kept");
    // Timing pulse with three, four and five satellites
    fix_3d <= 1'b1;
    for (int s = 3; s < 6; s++) begin
      sats_used <= 6'(s);
      utc_sec_tick <= 1'b1;
      @(posedge clk);
      utc_sec_tick <= 1'b0;
      @(posedge clk);
      chk(pps_out === (s > 3), "pulse on tick");
      repeat (10) @(posedge clk);
      fix_3d <= (s < 5);
      repeat (2) @(posedge clk);
      chk(pps_out === (s == 4), "fix loss drops pulse");
      repeat (30) @(posedge clk);
      chk(pps_out === 1'b0, "pulse ended");
      // First pulse of the run: exactly the bench pulse width
      if (s == 4)
        chk(pps_hi == 20, "pulse width");
    end
    // Tick without a fix gives no pulse
    utc_sec_tick <= 1'b1;
    @(posedge clk);
    utc_sec_tick <= 1'b0;
    @(posedge clk);
    chk(pps_out === 1'b0, "tick without fix");
    chk(fe == 0, "no frame errors");
    wrap_up();
  end
endmodule : testbench
